/* rlp_pkg.sv */
/*
 package for the program-memory lock and programming-mode block:
 array sizes, mode-select codes, lock levels and reset values.
 assumes nothing of its surroundings.
*/
package rlp_pkg;
	localparam int ENC_BYTES = 64;
	localparam int ENC_AW = 6;
	localparam int SIG_BYTES = 4;
	localparam int ADDR_W = 16;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// mode select codes, bit order a,b,c,d,e (a is msb)
	localparam logic [4:0] MODE_PROG_CODE = 5'h0F;
	localparam logic [4:0] MODE_PROG_ENC = 5'h0D;
	localparam logic [4:0] MODE_PROG_LB1 = 5'h1F;
	localparam logic [4:0] MODE_PROG_LB2 = 5'h1C;
	localparam logic [4:0] MODE_PROG_LB3 = 5'h16;
	// read modes compare a,c,d,e only
	localparam logic [3:0] MODE_VERIFY = 4'h3;
	localparam logic [3:0] MODE_SIG = 4'h0;
	typedef enum logic [1:0] {RLP_LVL1, RLP_LVL2, RLP_LVL3} rlp_level_e;
	typedef enum {RLP_IDLE, RLP_PULSE, RLP_WAIT_HIGH} rlp_state_e;
endpackage : rlp_pkg

/* rlp_rom_lock.sv */
/*
 program-memory lock and parallel programming / verify path.
 assumes: pins from the programmer are asynchronous and are synchronised here;
 high-voltage detect arrives as a logic level; code memory read is combinational.
*/
//
// Contract
// - an encryption array of 64 bytes reads all ones until programmed.
// - six address lines pick the encryption byte on every verify.
// - verify data is the xnor of encryption byte and code byte.
// - an ff code byte verifies as the encryption byte itself.
// - level 1 applies no lock; verify stays encrypted and table reads are plain.
// - level 2 blocks table reads from external code fetching internal bytes.
// - level 2 latches the external-access pin at reset and ignores it after.
// - level 3 acts as level 1 and also disables verify.
// - four factory signature bytes are read in signature mode.
// - address rides on port 1, port 2 bits 0-5, port 3 bits 4 and 5.
// - data rides on port 0, driven by the device only when reading.
// - verify and signature need strobe and ext_access_prog_voltage high with prog_voltage_high low, then the device drives data.
`timescale 1ns/10ps
module rlp_rom_lock
	import rlp_pkg::*;
#(
	parameter logic [31:0] SIG_WORD = 32'h5A3C_A501 // arbitrary signature value
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic rst_pin,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port2_in,
	input wire logic [7:0] port3_in,
	input wire logic [7:0] port0_in,
	input wire logic program_store_enable_n,
	input wire logic latch_strobe_prog_pulse,
	input wire logic ext_access_prog_voltage,
	input wire logic prog_voltage_high,
	input wire logic external_access_select,
	input wire logic [7:0] code_rd_data,
	input wire logic table_read_req,
	input wire logic table_read_from_ext,
	output logic [7:0] port0_out,
	output logic [7:0] port0_oe,
	output logic [rlp_pkg::ADDR_W-1:0] code_addr,
	output logic code_wr_pulse,
	output logic [7:0] code_wr_data,
	output logic table_read_allow,
	output logic ext_access_eff,
	output logic [1:0] security_level
);
	import rlp_pkg::*;

	// two-flop synchronisers for every pin
	// 1 reset + 4 ports of 8 + 5 control pins
	logic [37:0] sy1_q;
	logic [37:0] sy2_q;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sy1_q <= '0;
			sy2_q <= '0;
		end
		else
		begin
			sy1_q <= {rst_pin, port1_in, port2_in, port3_in, port0_in, program_store_enable_n,
				latch_strobe_prog_pulse, ext_access_prog_voltage, prog_voltage_high,
				external_access_select};
			sy2_q <= sy1_q;
		end
	end

	logic rst_s, program_store_enable_n_n_s, strobe_s, vpp_lvl_s, vhi_s, ea_s;
	logic [7:0] p1_s, p2_s, p3_s, p0_s;
	assign {rst_s, p1_s, p2_s, p3_s, p0_s, program_store_enable_n_n_s, strobe_s, vpp_lvl_s, vhi_s, ea_s} = sy2_q;

	logic [ADDR_W-1:0] addr;
	assign addr = {p3_s[5], p3_s[4], p2_s[5:0], p1_s};
	logic [4:0] msel;
	assign msel = {p2_s[6], p2_s[7], p3_s[3], p3_s[6], p3_s[7]};
	logic [3:0] rsel;
	assign rsel = {p2_s[6], p3_s[3], p3_s[6], p3_s[7]};
	logic setup_ok;
	assign setup_ok = rst_s && !program_store_enable_n_n_s;
	logic prog_cond;
	assign prog_cond = setup_ok && vhi_s && !strobe_s;
	logic read_cond;
	assign read_cond = setup_ok && strobe_s && vpp_lvl_s && !vhi_s;

	// encryption array and lock bits: flop storage standing in for nonvolatile cells
	logic [7:0] enc_q [ENC_BYTES];
	logic [2:0] lock_q;
	rlp_state_e st_q;
	logic fire;
	assign fire = (st_q == RLP_IDLE) && prog_cond;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			st_q <= RLP_IDLE;
		else
		begin
			case (st_q)
				RLP_IDLE: if (prog_cond) st_q <= RLP_PULSE;
				RLP_PULSE: st_q <= RLP_WAIT_HIGH;
				RLP_WAIT_HIGH: if (strobe_s) st_q <= RLP_IDLE;
				default: st_q <= RLP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < ENC_BYTES; i++)
				enc_q[i] <= ERASED_BYTE;
		end
		else if (fire && msel == MODE_PROG_ENC)
			enc_q[addr[ENC_AW-1:0]] <= enc_q[addr[ENC_AW-1:0]] & p0_s;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			lock_q <= 3'h0;
		else if (fire)
		begin
			// bits only ever set
			if (msel == MODE_PROG_LB1) lock_q[0] <= 1'b1;
			if (msel == MODE_PROG_LB2) lock_q[1] <= 1'b1;
			if (msel == MODE_PROG_LB3) lock_q[2] <= 1'b1;
		end
	end

	// level is taken at each pin reset, with the external-access pin
	logic rst_d1_q;
	logic [1:0] lvl_q;
	logic ea_latch_q;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_d1_q <= 1'b0;
			lvl_q <= RLP_LVL1;
			ea_latch_q <= 1'b0;
		end
		else
		begin
			rst_d1_q <= rst_s;
			if (rst_s)
			begin
				if (lock_q[0]) lvl_q <= RLP_LVL2;
				else if (lock_q[1]) lvl_q <= RLP_LVL3;
				else lvl_q <= RLP_LVL1;
				ea_latch_q <= ea_s;
			end
		end
	end

	logic lvl2, lvl3;
	assign lvl2 = (lvl_q == RLP_LVL2);
	assign lvl3 = (lvl_q == RLP_LVL3);

	function automatic logic [7:0] rlp_encrypt(input logic [7:0] code, input logic [7:0] key);
		rlp_encrypt = ~(code ^ key);
	endfunction : rlp_encrypt

	// read path output registers
	logic [7:0] p0_out_d;
	logic p0_oe_d;
	always_comb
	begin
		p0_out_d = 8'h00;
		p0_oe_d = 1'b0;
		if (read_cond && rsel == MODE_VERIFY && !lvl3)
		begin
			p0_out_d = rlp_encrypt(code_rd_data, enc_q[addr[ENC_AW-1:0]]);
			p0_oe_d = 1'b1;
		end
		else if (read_cond && rsel == MODE_SIG)
		begin
			p0_out_d = SIG_WORD[8*addr[1:0] +: 8];
			p0_oe_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			port0_out <= 8'h00;
			port0_oe <= 8'h00;
			code_addr <= '0;
			code_wr_pulse <= 1'b0;
			code_wr_data <= 8'h00;
		end
		else
		begin
			port0_out <= p0_out_d;
			port0_oe <= {8{p0_oe_d}};
			code_addr <= addr;
			code_wr_pulse <= fire && (msel == MODE_PROG_CODE);
			code_wr_data <= p0_s;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			table_read_allow <= 1'b0;
			ext_access_eff <= 1'b0;
			security_level <= 2'h0;
		end
		else
		begin
			table_read_allow <= table_read_req && !(lvl2 && table_read_from_ext);
			ext_access_eff <= lvl2 ? ea_latch_q : ea_s;
			security_level <= lvl_q;
		end
	end
endmodule : rlp_rom_lock

/* rlp_rom_lock_checker.sv */
/*
 port assertions for the lock and programming block.
 assumes: bound to rlp_rom_lock, one clock domain.
*/
`timescale 1ns/10ps
module rlp_rom_lock_checker (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] port0_in,
	input wire logic [7:0] port3_in,
	input wire logic prog_voltage_high,
	input wire logic table_read_req,
	input wire logic table_read_from_ext,
	input wire logic [7:0] port0_oe,
	input wire logic code_wr_pulse,
	input wire logic [7:0] code_wr_data,
	input wire logic table_read_allow,
	input wire logic [1:0] security_level
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	AST_OE_WHOLE: assert property (port0_oe == 8'h00 || port0_oe == 8'hFF)
		else $error("port0 enable split");
	AST_NO_READ_AT_VPP: assert property (prog_voltage_high [*5] |-> port0_oe == 8'h00)
		else $error("port0 driven in program mode");
	AST_WR_ONE: assert property (code_wr_pulse |=> !code_wr_pulse)
		else $error("write pulse too long");
	AST_WR_SRC: assert property (code_wr_pulse |->
		code_wr_data == $past(port0_in, 3) && $past(prog_voltage_high, 3))
		else $error("write data or voltage wrong");
	AST_NO_VERIFY_L3: assert property ((security_level == 2'd2 && port3_in[6]) [*5]
		|-> port0_oe == 8'h00)
		else $error("verify at level 3");
	AST_TBL_L2: assert property (security_level == 2'd1 && table_read_from_ext
		|=> !table_read_allow)
		else $error("external table read allowed");
	AST_TBL_L1: assert property (security_level == 2'd0 && table_read_req
		##1 security_level == 2'd0 |-> table_read_allow)
		else $error("table read refused");
	AST_LVL_HOLD: assert property (security_level != 2'd0 |=> security_level != 2'd0)
		else $error("lock level dropped");
endmodule : rlp_rom_lock_checker
bind rlp_rom_lock rlp_rom_lock_checker i_rlp_rom_lock_checker (.*);

/* rlp_code_mem.sv */
/*
 code store beside the block, 256 bytes, erased to ff.
 assumes: low address byte indexes it.
*/
`timescale 1ns/10ps
module rlp_code_mem (
	input wire logic clk_sys,
	input wire logic [15:0] code_addr,
	input wire logic code_wr_pulse,
	input wire logic [7:0] code_wr_data,
	output logic [7:0] code_rd_data
);
	logic [7:0] mem_q [256];
	initial
	begin
		foreach (mem_q[i])
			mem_q[i] = 8'hFF;
	end
	always @(posedge clk_sys)
	begin
		if (code_wr_pulse)
			mem_q[code_addr[7:0]] <= code_wr_data;
	end
	assign code_rd_data = mem_q[code_addr[7:0]];
endmodule : rlp_code_mem

/* rlp_rom_lock_tb.sv */
/*
 bench: program, verify, signature, lock levels.
 assumes: rlp_code_mem as code store.
*/
`timescale 1ns/10ps
module rlp_rom_lock_tb;
	import rlp_pkg::*;
	logic clk_sys = 0, reset_n = 0, rst_pin = 1, program_store_enable_n = 0;
	logic latch_strobe_prog_pulse = 1, ext_access_prog_voltage = 1, prog_voltage_high = 0;
	logic external_access_select = 0, table_read_req = 0, table_read_from_ext = 0;
	logic [7:0] port0_in = 0, port1_in = 0, port2_in = 0, port3_in = 0;
	logic [7:0] port0_out, port0_oe, code_wr_data, code_rd_data;
	logic [15:0] code_addr;
	logic code_wr_pulse, table_read_allow, ext_access_eff;
	logic [1:0] security_level;
	int fail_count = 0, comparisons = 0, cyc = 0;
	localparam logic [31:0] SIG = 32'h5A3C_A501; // arbitrary
	localparam logic [28:0] ROWS [7] = '{{5'h03, 16'h0010, 8'h55}, {5'h03, 16'h0011, 8'hFF},
		{5'h03, 16'h0050, 8'h3C}, {5'h00, 16'h0000, SIG[7:0]}, {5'h00, 16'h0001, SIG[15:8]},
		{5'h00, 16'h0002, SIG[23:16]}, {5'h00, 16'h0003, SIG[31:24]}};
	rlp_rom_lock #(.SIG_WORD(SIG)) i_rlp_rom_lock (.*);
	rlp_code_mem i_rlp_code_mem (.*);
	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic pin(logic [4:0] m, logic [15:0] a, logic [7:0] d, logic p);
		port1_in <= a[7:0];
		port2_in <= {m[3], m[4], a[13:8]};
		port3_in <= {m[0], m[1], a[15:14], m[2], 3'h0};
		port0_in <= d;
		prog_voltage_high <= p;
		repeat (4) @(posedge clk_sys);
		latch_strobe_prog_pulse <= !p;
		repeat (4) @(posedge clk_sys);
		latch_strobe_prog_pulse <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : pin
	task automatic complete_run;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			complete_run;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		chk("level", 8'h00, {6'h0, security_level});
		pin(MODE_PROG_CODE, 16'h0010, 8'h96, 1);
		pin(MODE_PROG_ENC, 16'h0010, 8'h3C, 1);
		foreach (ROWS[i])
		begin
			pin(ROWS[i][28:24], ROWS[i][23:8], 8'h00, 0);
			chk("data", ROWS[i][7:0], port0_out);
			chk("oe", 8'hFF, port0_oe);
		end
		table_read_req <= 1'b1;
		table_read_from_ext <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("table", 8'h01, {7'h0, table_read_allow});
		pin(MODE_PROG_LB1, 16'h0000, 8'h00, 1);
		chk("level", 8'h01, {6'h0, security_level});
		chk("table", 8'h00, {7'h0, table_read_allow});
		rst_pin <= 1'b0;
		external_access_select <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("ext", 8'h00, {7'h0, ext_access_eff});
		rst_pin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("ext", 8'h01, {7'h0, ext_access_eff});
		external_access_select <= 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		pin(MODE_PROG_LB2, 16'h0000, 8'h00, 1);
		chk("level", 8'h02, {6'h0, security_level});
		pin(5'h03, 16'h0010, 8'h00, 0);
		chk("oe", 8'h00, port0_oe);
		pin(MODE_PROG_LB3, 16'h0000, 8'h00, 1);
		chk("level", 8'h02, {6'h0, security_level});
		complete_run;
	end
endmodule : rlp_rom_lock_tb
